// file: acw_blk_src.sv
/*
 * Model of the other function blocks whose live values feed the unit.
 * Assumes the bench writes one block at a time on the program clock.
 */
module acw_blk_src
    import acw_pkg::*;
#(
    parameter int NUM_SRC = 8
) (
    input wire logic mclk_i,
    input wire logic wr_i,
    input wire logic [ACW_SEL_W-1:0] idx_i,
    input wire logic signed [ACW_VAL_W-1:0] val_i,
    output logic [NUM_SRC*ACW_VAL_W-1:0] blk_vals_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Power-up pattern so an unset block never reads as zero, then
    // one block value stored per write; only existing numbers are written
    initial begin
        for (int k = 0; k < NUM_SRC; k++) begin
            blk_vals_o[k*ACW_VAL_W +: ACW_VAL_W] = 16'h7000 + k[15:0];
        end
        forever begin
            @(posedge mclk_i);
            if (wr_i && (idx_i < NUM_SRC)) begin
                blk_vals_o[idx_i*ACW_VAL_W +: ACW_VAL_W] <= val_i;
            end
        end
    end
endmodule

// file: acw_pkg.sv
/*
 * Package for the analog compare, watch and amplify unit: widths, ranges,
 * reset values and the comparator mode encoding.
 * Assumes one program clock; values are signed integers as in the program.
 */
package acw_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ACW_VAL_W = 16;
    localparam int ACW_GAIN_W = 12;
    localparam int ACW_OFS_W = 15;
    localparam int ACW_THR_W = 16;
    localparam int ACW_SEL_W = 3;
    localparam int ACW_WIDE_W = 32;

    // ------------------------------------------------------------------
    // Ranges and scaling
    // ------------------------------------------------------------------
    localparam logic signed [ACW_GAIN_W-1:0] ACW_GAIN_MAX = 12'sd1000;
    localparam logic signed [ACW_GAIN_W-1:0] ACW_GAIN_MIN = -12'sd1000;
    localparam logic signed [ACW_GAIN_W-1:0] ACW_GAIN_OLD_MIN = 12'sd0;
    localparam logic signed [ACW_OFS_W-1:0] ACW_OFS_MAX = 15'sd10000;
    localparam logic signed [ACW_OFS_W-1:0] ACW_OFS_MIN = -15'sd10000;
    localparam logic signed [ACW_THR_W-1:0] ACW_WIN_MAX = 16'sd20000;
    localparam logic signed [ACW_THR_W-1:0] ACW_WIN_MIN = 16'sd0;
    localparam logic signed [ACW_VAL_W-1:0] ACW_RAW_MAX = 16'sd1000;
    localparam logic signed [ACW_WIDE_W-1:0] ACW_GAIN_DIV = 32'sd100;
    localparam logic signed [ACW_WIDE_W-1:0] ACW_OUT_MAX = 32'sd32767;
    localparam logic signed [ACW_WIDE_W-1:0] ACW_OUT_MIN = -32'sd32768;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic signed [ACW_VAL_W-1:0] ACW_VAL_RST = 16'sh0000;

    // Comparator mode
    typedef enum logic [0:0] {
        ACW_CMP_ONOFF = 1'b0,
        ACW_CMP_LEGACY = 1'b1
    } acw_mode_e;

endpackage

// file: acw_unit.sv
/*
 * Analog comparator, analog watchdog and analog amplifier sharing one
 * gain/offset scaling stage (the legacy comparator adds the offset before the gain; with old_variant_i the
 * watchdog and amplifier gain is limited to 0 and above, the comparator gain is not), evaluated on each program-cycle enable.
 * Assumes inputs come from logic on mclk_i (no synchronisers needed) and
 * that retain_i reflects the retentivity selection of the watchdog.
 */

module acw_unit
    import acw_pkg::*;
#(
    parameter int NUM_SRC = 8
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic cycle_en_i,
    input wire logic retain_i,
    input wire logic old_variant_i,
    input wire logic legacy_cmp_i,
    input wire logic raw_channel_i,
    input wire logic signed [ACW_VAL_W-1:0] first_analog_in_i,
    input wire logic signed [ACW_VAL_W-1:0] second_analog_in_i,
    input wire logic signed [ACW_GAIN_W-1:0] gain_i,
    input wire logic signed [ACW_OFS_W-1:0] offset_i,
    input wire logic signed [ACW_THR_W-1:0] on_thr_i,
    input wire logic signed [ACW_THR_W-1:0] off_thr_i,
    input wire logic signed [ACW_THR_W-1:0] delta_i,
    input wire logic [1:0] decimals_i,
    input wire logic wd_en_i,
    input wire logic signed [ACW_THR_W-1:0] upper_const_i,
    input wire logic signed [ACW_THR_W-1:0] lower_const_i,
    input wire logic upper_use_blk_i,
    input wire logic lower_use_blk_i,
    input wire logic [ACW_SEL_W-1:0] upper_blk_i,
    input wire logic [ACW_SEL_W-1:0] lower_blk_i,
    input wire logic [NUM_SRC*ACW_VAL_W-1:0] blk_vals_i,
    output logic cmp_q_o,
    output logic wd_q_o,
    output logic signed [ACW_VAL_W-1:0] wd_ref_o,
    output logic signed [ACW_VAL_W-1:0] scaled_analog_out_o,
    output logic signed [ACW_WIDE_W-1:0] cmp_diff_o,
    output logic [1:0] decimals_o
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (NUM_SRC < 1 || NUM_SRC > (1 << ACW_SEL_W)) begin : g_chk
        $error("NUM_SRC must lie between 1 and the selector range");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic cmp_q;
        logic wd_q;
        logic wd_en_d;
        logic signed [ACW_VAL_W-1:0] wd_ref;
        logic signed [ACW_VAL_W-1:0] amp;
        logic signed [ACW_WIDE_W-1:0] diff;
        logic [1:0] dec;
    } acw_state_s;

    acw_state_s st_r;
    acw_state_s st_nxt;

    // Clip a value into a range
    function automatic logic signed [ACW_WIDE_W-1:0] clip(
        input logic signed [ACW_WIDE_W-1:0] v,
        input logic signed [ACW_WIDE_W-1:0] lo,
        input logic signed [ACW_WIDE_W-1:0] hi
    );
        logic signed [ACW_WIDE_W-1:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    // Raw value: analog channels limited to 0..1000
    function automatic logic signed [ACW_WIDE_W-1:0] raw_of(
        input logic signed [ACW_VAL_W-1:0] v,
        input logic is_chan
    );
        logic signed [ACW_WIDE_W-1:0] w;
        w = ACW_WIDE_W'(v);
        if (is_chan) begin
            w = clip(w, 32'sd0, ACW_WIDE_W'(ACW_RAW_MAX));
        end
        return w;
    endfunction

    // Actual value: input times gain (hundredths) plus offset
    function automatic logic signed [ACW_WIDE_W-1:0] scale(
        input logic signed [ACW_WIDE_W-1:0] x,
        input logic signed [ACW_WIDE_W-1:0] g,
        input logic signed [ACW_WIDE_W-1:0] o
    );
        return (x * g) / ACW_GAIN_DIV + o;
    endfunction

    // Effective parameters
    logic signed [ACW_WIDE_W-1:0] gain_w;
    logic signed [ACW_WIDE_W-1:0] gain_old_w;
    logic signed [ACW_WIDE_W-1:0] ofs_w;
    logic signed [ACW_WIDE_W-1:0] ax_w;
    logic signed [ACW_WIDE_W-1:0] ay_w;
    logic signed [ACW_WIDE_W-1:0] upper_w;
    logic signed [ACW_WIDE_W-1:0] lower_w;

    // Gain, offset and window thresholds limited to their ranges
    always_comb begin
        gain_w = clip(ACW_WIDE_W'(gain_i), ACW_WIDE_W'(ACW_GAIN_MIN),
                      ACW_WIDE_W'(ACW_GAIN_MAX));
        gain_old_w = gain_w;
        if (old_variant_i) begin
            gain_old_w = clip(gain_w, ACW_WIDE_W'(ACW_GAIN_OLD_MIN),
                              ACW_WIDE_W'(ACW_GAIN_MAX));
        end
        ofs_w = clip(ACW_WIDE_W'(offset_i), ACW_WIDE_W'(ACW_OFS_MIN),
                     ACW_WIDE_W'(ACW_OFS_MAX));
        ax_w = raw_of(first_analog_in_i, raw_channel_i);
        ay_w = raw_of(second_analog_in_i, raw_channel_i);
        // Threshold source: constant or live block value
        upper_w = ACW_WIDE_W'(upper_const_i);
        lower_w = ACW_WIDE_W'(lower_const_i);
        if (upper_use_blk_i) begin
            upper_w = ACW_WIDE_W'($signed(blk_vals_i[upper_blk_i*ACW_VAL_W +: ACW_VAL_W]));
        end
        if (lower_use_blk_i) begin
            lower_w = ACW_WIDE_W'($signed(blk_vals_i[lower_blk_i*ACW_VAL_W +: ACW_VAL_W]));
        end
        upper_w = clip(upper_w, ACW_WIDE_W'(ACW_WIN_MIN), ACW_WIDE_W'(ACW_WIN_MAX));
        lower_w = clip(lower_w, ACW_WIDE_W'(ACW_WIN_MIN), ACW_WIDE_W'(ACW_WIN_MAX));
    end

    // ------------------------------------------------------------------
    // Next state: one evaluation per program cycle
    // ------------------------------------------------------------------
    logic signed [ACW_WIDE_W-1:0] cur_w;
    logic signed [ACW_WIDE_W-1:0] diff_w;
    logic signed [ACW_WIDE_W-1:0] on_w;
    logic signed [ACW_WIDE_W-1:0] off_w;
    logic signed [ACW_WIDE_W-1:0] ref_w;

    always_comb begin
        st_nxt = st_r;
        on_w = ACW_WIDE_W'(on_thr_i);
        off_w = ACW_WIDE_W'(off_thr_i);
        cur_w = scale(ax_w, gain_old_w, ofs_w);
        ref_w = ACW_WIDE_W'(st_r.wd_ref);
        diff_w = scale(ax_w, gain_w, ofs_w) - scale(ay_w, gain_w, ofs_w);
        if (legacy_cmp_i) begin
            diff_w = (ax_w + ofs_w) * gain_w / ACW_GAIN_DIV
                   - (ay_w + ofs_w) * gain_w / ACW_GAIN_DIV;
        end
        if (cycle_en_i) begin
            st_nxt.diff = diff_w;
            st_nxt.dec = decimals_i;
            // Comparator on raw integers
            if (legacy_cmp_i) begin
                st_nxt.cmp_q = diff_w > ACW_WIDE_W'(delta_i);
            end else if (on_w >= off_w) begin
                if (diff_w > on_w) begin
                    st_nxt.cmp_q = 1'b1;
                end else if (diff_w <= off_w) begin
                    st_nxt.cmp_q = 1'b0;
                end // hold in between
            end else begin
                st_nxt.cmp_q = (diff_w >= on_w) && (diff_w < off_w);
            end
            // Watchdog
            st_nxt.wd_en_d = wd_en_i;
            if (!wd_en_i) begin
                st_nxt.wd_q = 1'b0;
            end else begin
                if (!st_r.wd_en_d) begin
                    ref_w = clip(cur_w, ACW_OUT_MIN, ACW_OUT_MAX);
                    st_nxt.wd_ref = ACW_VAL_W'(ref_w);
                end
                st_nxt.wd_q = (cur_w > ref_w + upper_w) || (cur_w < ref_w - lower_w);
            end
            // Amplifier with saturation
            st_nxt.amp = ACW_VAL_W'(clip(cur_w, ACW_OUT_MIN, ACW_OUT_MAX));
        end
    end

    // ------------------------------------------------------------------
    // Register, retentive watchdog state kept over reset
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_r.cmp_q <= 1'b0;
            st_r.amp <= ACW_VAL_RST;
            st_r.diff <= '0;
            st_r.dec <= 2'h0;
            if (!retain_i) begin
                st_r.wd_q <= 1'b0;
                st_r.wd_en_d <= 1'b0;
                st_r.wd_ref <= ACW_VAL_RST;
            end
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state
    assign cmp_q_o = st_r.cmp_q;
    assign wd_q_o = st_r.wd_q;
    assign wd_ref_o = st_r.wd_ref;
    assign scaled_analog_out_o = st_r.amp;
    assign cmp_diff_o = st_r.diff;
    assign decimals_o = st_r.dec;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Comparator window case, On below Off
    a_cmp_window: assert property (@(posedge mclk_i) disable iff (reset_i)
        (cycle_en_i && !legacy_cmp_i && on_w < off_w)
        |=> cmp_q_o == ($past(diff_w) >= $past(on_w) && $past(diff_w) < $past(off_w)))
        else $error("comparator window wrong");
    // Hysteresis case, set above On
    a_cmp_set: assert property (@(posedge mclk_i) disable iff (reset_i)
        (cycle_en_i && !legacy_cmp_i && on_w >= off_w && diff_w > on_w)
        |=> cmp_q_o)
        else $error("comparator not set");
    // Hysteresis case, clear at or below Off
    a_cmp_clear: assert property (@(posedge mclk_i) disable iff (reset_i)
        (cycle_en_i && !legacy_cmp_i && on_w >= off_w && diff_w <= off_w)
        |=> !cmp_q_o)
        else $error("comparator not cleared");
    // Hysteresis band keeps the last output
    a_cmp_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
        (cycle_en_i && !legacy_cmp_i && on_w >= off_w && diff_w <= on_w && diff_w > off_w)
        |=> $stable(cmp_q_o))
        else $error("hysteresis not held");
    // Legacy mode, single delta threshold
    a_cmp_legacy: assert property (@(posedge mclk_i) disable iff (reset_i)
        (cycle_en_i && legacy_cmp_i)
        |=> cmp_q_o == ($past(diff_w) > $past(delta_i)))
        else $error("legacy compare wrong");
    // Difference handed out as evaluated
    a_diff_copy: assert property (@(posedge mclk_i) disable iff (reset_i)
        cycle_en_i
        |=> cmp_diff_o == $past(diff_w))
        else $error("comparator difference wrong");
    // Decimal places only passed through
    a_dec_copy: assert property (@(posedge mclk_i) disable iff (reset_i)
        cycle_en_i
        |=> decimals_o == $past(decimals_i))
        else $error("decimal places wrong");

    // Watchdog output cleared while disabled
    a_wd_low_clear: assert property (@(posedge mclk_i) disable iff (reset_i)
        (cycle_en_i && !wd_en_i)
        |=> !wd_q_o)
        else $error("watchdog not cleared");
    // Reference taken on the enable edge
    a_wd_capture: assert property (@(posedge mclk_i) disable iff (reset_i)
        (cycle_en_i && wd_en_i && !st_r.wd_en_d && cur_w >= ACW_OUT_MIN && cur_w <= ACW_OUT_MAX)
        |=> wd_ref_o == ACW_VAL_W'($past(cur_w)))
        else $error("reference not stored");
    // Fresh reference sits inside its own window
    a_wd_first_quiet: assert property (@(posedge mclk_i) disable iff (reset_i)
        (cycle_en_i && wd_en_i && !st_r.wd_en_d && cur_w >= ACW_OUT_MIN && cur_w <= ACW_OUT_MAX)
        |=> !wd_q_o)
        else $error("watchdog set on capture");
    // Reference kept while enable stays high
    a_wd_ref_keep: assert property (@(posedge mclk_i) disable iff (reset_i)
        (cycle_en_i && wd_en_i && st_r.wd_en_d)
        |=> $stable(wd_ref_o))
        else $error("reference changed while enabled");
    // Output follows the window around the reference
    a_wd_out_window: assert property (@(posedge mclk_i) disable iff (reset_i)
        (cycle_en_i && wd_en_i && st_r.wd_en_d)
        |=> wd_q_o == ($past(cur_w) > $past(ref_w) + $past(upper_w)
            || $past(cur_w) < $past(ref_w) - $past(lower_w)))
        else $error("watchdog window wrong");
    // Retentive reset leaves watchdog state alone
    a_retain_keep: assert property (@(posedge mclk_i)
        (reset_i && retain_i)
        |=> $stable(wd_q_o) && $stable(wd_ref_o))
        else $error("retentive state lost");
    // Plain reset clears watchdog state
    a_reset_wd_clear: assert property (@(posedge mclk_i)
        (reset_i && !retain_i)
        |=> !wd_q_o && wd_ref_o == 16'sh0000)
        else $error("watchdog reset did not clear");

    // Amplifier passes an in-range value unchanged
    a_amp_value: assert property (@(posedge mclk_i) disable iff (reset_i)
        (cycle_en_i && cur_w >= ACW_OUT_MIN && cur_w <= ACW_OUT_MAX)
        |=> scaled_analog_out_o == ACW_VAL_W'($past(cur_w)))
        else $error("amplifier value wrong");
    // Amplifier saturates high
    a_amp_sat: assert property (@(posedge mclk_i) disable iff (reset_i)
        (cycle_en_i && cur_w > ACW_OUT_MAX)
        |=> scaled_analog_out_o == 16'sh7FFF)
        else $error("amplifier did not saturate");
    // Amplifier saturates low
    a_amp_low_sat: assert property (@(posedge mclk_i) disable iff (reset_i)
        (cycle_en_i && cur_w < ACW_OUT_MIN)
        |=> scaled_analog_out_o == 16'sh8000)
        else $error("amplifier did not saturate low");

    // Comparator and amplifier stand between program cycles
    a_idle_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
        !cycle_en_i
        |=> $stable(scaled_analog_out_o) && $stable(cmp_q_o))
        else $error("changed outside program cycle");
    // Watchdog and difference stand between program cycles
    a_wd_idle_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
        !cycle_en_i
        |=> $stable(wd_q_o) && $stable(wd_ref_o) && $stable(cmp_diff_o))
        else $error("watchdog changed outside program cycle");
    // Reset clears comparator and amplifier
    a_reset_clear: assert property (@(posedge mclk_i)
        reset_i
        |=> !cmp_q_o && scaled_analog_out_o == 16'sh0000)
        else $error("reset did not clear");

endmodule

// file: tb_top.sv
/*
 * Self-checking bench for the compare, watch and amplify unit.
 * Assumes one 25 MHz program clock and a synchronous active high reset.
 */
module tb_top
    import acw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic mclk_i, reset_i, cycle_en_i, retain_i, old_variant_i, legacy_cmp_i, raw_channel_i;
    logic wd_en_i, upper_use_blk_i, lower_use_blk_i, blk_wr, cmp_q_o, wd_q_o;
    logic signed [ACW_VAL_W-1:0] x_i, y_i, blk_val, wd_ref_o, amp_o;
    logic signed [ACW_GAIN_W-1:0] gain_i;
    logic signed [ACW_OFS_W-1:0] offset_i;
    logic signed [ACW_THR_W-1:0] on_thr_i, off_thr_i, delta_i, upper_const_i, lower_const_i;
    logic [1:0] decimals_i, decimals_o;
    logic [ACW_SEL_W-1:0] upper_blk_i, lower_blk_i, blk_idx;
    logic [8*ACW_VAL_W-1:0] blk_vals;
    logic signed [ACW_WIDE_W-1:0] cmp_diff_o;
    int n_errors = 0;
    int n_checks = 0;

    acw_blk_src #(.NUM_SRC(8)) i_blk (.mclk_i(mclk_i), .wr_i(blk_wr), .idx_i(blk_idx),
        .val_i(blk_val), .blk_vals_o(blk_vals));

    acw_unit #(.NUM_SRC(8)) i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .cycle_en_i(cycle_en_i),
        .retain_i(retain_i), .old_variant_i(old_variant_i), .legacy_cmp_i(legacy_cmp_i),
        .raw_channel_i(raw_channel_i), .first_analog_in_i(x_i), .second_analog_in_i(y_i),
        .gain_i(gain_i), .offset_i(offset_i), .on_thr_i(on_thr_i), .off_thr_i(off_thr_i),
        .delta_i(delta_i), .decimals_i(decimals_i), .wd_en_i(wd_en_i),
        .upper_const_i(upper_const_i), .lower_const_i(lower_const_i),
        .upper_use_blk_i(upper_use_blk_i), .lower_use_blk_i(lower_use_blk_i),
        .upper_blk_i(upper_blk_i), .lower_blk_i(lower_blk_i), .blk_vals_i(blk_vals),
        .cmp_q_o(cmp_q_o), .wd_q_o(wd_q_o), .wd_ref_o(wd_ref_o),
        .scaled_analog_out_o(amp_o), .cmp_diff_o(cmp_diff_o), .decimals_o(decimals_o));

    // ------------------------------------------------------------------
    // Clock, watchdog and tasks
    // ------------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    // Cut a hang short
    initial begin
        #200us;
        n_errors++;
        give_verdict();
    end

    task automatic give_verdict();
        if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic signed [31:0] e, input logic signed [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // One program cycle; outputs settled on return
    task automatic strobe(input logic signed [15:0] x, input logic signed [15:0] y);
        @(posedge mclk_i);
        x_i <= x;
        y_i <= y;
        cycle_en_i <= 1'b1;
        @(posedge mclk_i);
        cycle_en_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic do_reset(input int n);
        @(posedge mclk_i);
        reset_i <= 1'b1;
        repeat (n) @(posedge mclk_i);
        reset_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic amp(input logic signed [15:0] x, input logic signed [11:0] g,
        input logic signed [14:0] o, input logic old, input logic signed [31:0] e);
        gain_i <= g;
        offset_i <= o;
        old_variant_i <= old;
        strobe(x, 16'sh0000);
        chk("amp_out", e, amp_o);
    endtask

    task automatic cmp(input logic signed [15:0] x, input logic signed [15:0] y, input logic e);
        strobe(x, y);
        chk("cmp_q", {31'h0, e}, {31'h0, cmp_q_o});
    endtask

    task automatic wd(input logic signed [15:0] x, input logic e);
        strobe(x, 16'sh0000);
        chk("wd_q", {31'h0, e}, {31'h0, wd_q_o});
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        {reset_i, cycle_en_i, retain_i, old_variant_i, legacy_cmp_i, raw_channel_i} = 6'h00;
        {wd_en_i, upper_use_blk_i, lower_use_blk_i, blk_wr} = 4'h0;
        {x_i, y_i, blk_val, upper_const_i, lower_const_i} = 80'h0;
        {gain_i, offset_i, on_thr_i, off_thr_i, delta_i} = 75'h0;
        {decimals_i, upper_blk_i, lower_blk_i, blk_idx} = 11'h000;
        do_reset(16);
        chk("wd_ref", 0, wd_ref_o);
        // Amplifier scaling, clipping and saturation
        amp(16'sd500, 12'sd150, -15'sd20, 1'b0, 730);
        amp(-16'sd7, 12'sd50, 15'sd0, 1'b0, -3);
        amp(16'sd100, 12'sd2000, 15'sd0, 1'b0, 1000);
        amp(16'sd1, 12'sd100, 15'sd16000, 1'b0, 10001);
        amp(16'sd100, -12'sd100, 15'sd5, 1'b0, -95);
        amp(16'sd100, -12'sd100, 15'sd5, 1'b1, 5);
        amp(16'sd10000, 12'sd1000, 15'sd0, 1'b0, 32767);
        amp(-16'sd10000, 12'sd1000, 15'sd0, 1'b0, -32768);
        raw_channel_i <= 1'b1;
        amp(16'sd1500, 12'sd100, 15'sd0, 1'b0, 1000);
        raw_channel_i <= 1'b0;
        // Comparator with hysteresis, then window, then legacy
        on_thr_i <= 16'sd100;
        off_thr_i <= 16'sd50;
        decimals_i <= 2'h3;
        gain_i <= 12'sd200;
        offset_i <= 15'sd7;
        cmp(16'sd160, 16'sd100, 1'b1);
        chk("cmp_diff", 120, cmp_diff_o);
        chk("decimals", 3, {30'h0, decimals_o});
        gain_i <= 12'sd100;
        cmp(16'sd280, 16'sd200, 1'b1);
        cmp(16'sd250, 16'sd200, 1'b0);
        cmp(16'sd280, 16'sd200, 1'b0);
        on_thr_i <= 16'sd50;
        off_thr_i <= 16'sd100;
        cmp(16'sd300, 16'sd200, 1'b0);
        cmp(16'sd250, 16'sd200, 1'b1);
        cmp(16'sd299, 16'sd200, 1'b1);
        cmp(16'sd249, 16'sd200, 1'b0);
        legacy_cmp_i <= 1'b1;
        delta_i <= 16'sd100;
        on_thr_i <= -16'sd20000;
        off_thr_i <= -16'sd20000;
        cmp(16'sd300, 16'sd200, 1'b0);
        cmp(16'sd301, 16'sd200, 1'b1);
        // No strobe: outputs stand
        x_i <= 16'sd0;
        repeat (3) @(posedge mclk_i);
        chk("cmp_q", 1, {31'h0, cmp_q_o});
        legacy_cmp_i <= 1'b0;
        // Watchdog window around the stored reference
        gain_i <= 12'sd200;
        offset_i <= 15'sd10;
        upper_const_i <= 16'sd200;
        lower_const_i <= 16'sd100;
        wd_en_i <= 1'b1;
        wd(16'sd500, 1'b0);
        chk("wd_ref", 1010, wd_ref_o);
        chk("amp_out", 1010, amp_o);
        wd(16'sd605, 1'b1);
        wd(16'sd600, 1'b0);
        wd(16'sd449, 1'b1);
        wd(16'sd450, 1'b0);
        chk("wd_ref", 1010, wd_ref_o);
        @(posedge mclk_i);
        {blk_wr, blk_idx, blk_val} <= {1'b1, 3'h3, 16'sd50};
        {upper_use_blk_i, upper_blk_i} <= {1'b1, 3'h3};
        @(posedge mclk_i);
        blk_wr <= 1'b0;
        wd(16'sd531, 1'b1);
        lower_const_i <= -16'sd5;
        wd(16'sd500, 1'b0);
        wd(16'sd499, 1'b1);
        // Retentive reset, then disable, then plain reset
        retain_i <= 1'b1;
        do_reset(2);
        chk("wd_q", 1, {31'h0, wd_q_o});
        chk("wd_ref", 1010, wd_ref_o);
        chk("amp_out", 0, amp_o);
        wd_en_i <= 1'b0;
        wd(16'sd499, 1'b0);
        retain_i <= 1'b0;
        do_reset(2);
        chk("wd_ref", 0, wd_ref_o);
        give_verdict();
    end
endmodule
